// File: hw/pwr_dev_end.sv
/*
 * device end: derives the power state from chip enable and hard reset
 * and drives each digital pad's output enable, input enable and pull.
 * assumes the host keeps both link signals driven and ordered.
 */
`timescale 1ns/1ps
module pwr_dev_end #(
    parameter int PADS = pwr_seq_pkg::NUM_PADS   // pad count
) (
    input  wire logic            i_clk,          // system clock
    input  wire logic            i_rst,          // sync reset, high
    pwr_seq_if.dev_mp            link,           // enable and reset in
    input  wire logic            i_io_supply,    // io supply present
    input  wire logic            i_fw_cfg_done,  // firmware set up pads
    input  wire logic [PADS-1:0] i_fw_oe,        // firmware output enables
    input  wire logic [PADS-1:0] i_fw_pull,      // firmware pull enables
    output logic [1:0]           o_state,        // current power state
    output logic [PADS-1:0]      o_pad_oe,       // pad driver enable
    output logic [PADS-1:0]      o_pad_ie,       // pad input enable
    output logic [PADS-1:0]      o_pad_pull      // 96k pull enable
);

    initial begin
        if (PADS < 1) begin
            $error("pad count must be at least one");
        end
    end

    // ---------------------------------------------------------------
    // power state
    // ---------------------------------------------------------------
    pwr_seq_pkg::dev_state_type state_reg;       // current state
    pwr_seq_pkg::dev_state_type state_next;      // next state
    logic [PADS-1:0]            oe_reg;          // output enables
    logic [PADS-1:0]            oe_next;
    logic [PADS-1:0]            ie_reg;          // input enables
    logic [PADS-1:0]            ie_next;
    logic [PADS-1:0]            pull_reg;        // pull enables
    logic [PADS-1:0]            pull_next;

    // state follows the link levels each cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pwr_seq_pkg::DEV_POWER_DOWN,
            pwr_seq_pkg::DEV_POR,
            pwr_seq_pkg::DEV_DEFAULT,
            pwr_seq_pkg::DEV_OPERATE: begin
                if (!link.chip_en || !i_io_supply) begin
                    // enable low or io supply loss decides; order vs reset ignored
                    state_next = pwr_seq_pkg::DEV_POWER_DOWN;
                end else if (!link.hard_reset_low) begin
                    state_next = pwr_seq_pkg::DEV_POR;
                end else if (i_fw_cfg_done &&
                             state_reg != pwr_seq_pkg::DEV_POR) begin
                    // firmware takes over from any state except DEV_POR
                    state_next = pwr_seq_pkg::DEV_OPERATE;
                end else if (state_reg != pwr_seq_pkg::DEV_OPERATE) begin
                    state_next = pwr_seq_pkg::DEV_DEFAULT;
                end
            end
            default: begin
                state_next = pwr_seq_pkg::DEV_POWER_DOWN;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // pad control
    // ---------------------------------------------------------------
    // pad settings from the next state, so they match o_state
    always_comb begin
        case (state_next)
            pwr_seq_pkg::DEV_POWER_DOWN: begin
                oe_next   = '0;
                ie_next   = '0;
                pull_next = '0;
            end
            pwr_seq_pkg::DEV_POR: begin
                oe_next   = '0;
                ie_next   = '0;
                pull_next = '1;
            end
            pwr_seq_pkg::DEV_DEFAULT: begin
                oe_next   = '0;
                ie_next   = '1;
                pull_next = '1;
            end
            pwr_seq_pkg::DEV_OPERATE: begin
                oe_next   = i_fw_oe;
                ie_next   = ~i_fw_oe;
                pull_next = i_fw_pull;
            end
            default: begin
                oe_next   = '0;
                ie_next   = '0;
                pull_next = '0;
            end
        endcase
    end

    // register state and pad controls
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= pwr_seq_pkg::DEV_POWER_DOWN;
            oe_reg    <= '0;
            ie_reg    <= '0;
            pull_reg  <= '0;
        end else begin
            state_reg <= state_next;
            oe_reg    <= oe_next;
            ie_reg    <= ie_next;
            pull_reg  <= pull_next;
        end
    end

    assign o_state    = state_reg;
    assign o_pad_oe   = oe_reg;
    assign o_pad_ie   = ie_reg;
    assign o_pad_pull = pull_reg;

endmodule

// File: hw/pwr_seq_pkg.sv
/*
 * shared constants for the power enable / hard reset sequencer pair:
 * timing counts, pad control layout and the sequencer states.
 * assumes a single 50 MHz clock shared by both ends.
 */
package pwr_seq_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000; // system clock rate
    localparam int RST_HOLD_MS     = 5;          // least enable-to-release
    // least time as ms times whole cycles per ms, no round-up
    localparam int RST_HOLD_CYC    =
        (RST_HOLD_MS * (CLK_HZ / 1000) + 0);
    localparam int OSC_SETTLE_CYC  = 16;         // crystal settle preset
    localparam int IO_TO_EN_CYC    = 1;          // supply-good to enable

    // ---------------------------------------------------------------
    // pads
    // ---------------------------------------------------------------
    localparam int NUM_PADS        = 9;          // digital pad count
    localparam int PULL_KOHM       = 96;         // pull resistor value

    // ---------------------------------------------------------------
    // device power states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        DEV_POWER_DOWN,                          // core supply off
        DEV_POR,                                 // core on, held in reset
        DEV_DEFAULT,                             // out of reset, unconfigured
        DEV_OPERATE                              // firmware owns the pads
    } dev_state_type;

    // host sequencer states
    typedef enum logic [2:0] {
        HST_OFF,                                 // everything low
        HST_WAIT_IO,                             // wait for supply-good
        HST_HOLD,                                // enable high, reset held
        HST_RUN,                                 // reset released
        HST_DOWN                                 // power-down taken
    } host_state_type;

endpackage

// File: hw/pwr_seq_if.sv
/*
 * link between host sequencer and device: chip enable and hard reset,
 * both always driven by the host end.
 * assumes both ends share i_clk.
 */
`timescale 1ns/1ps
interface pwr_seq_if;
    logic chip_en;                               // core power enable
    logic hard_reset_low;                        // active-low hard reset

    modport host_mp (output chip_en, output hard_reset_low);
    modport dev_mp  (input  chip_en, input  hard_reset_low);
endinterface

// File: hw/pwr_host_end.sv
/*
 * host end: drives chip enable and hard reset. raises enable once the
 * io supply is good, holds reset for HOLD_CYC cycles, and on a
 * power-down request drops both in the same cycle.
 * assumes i_io_good reflects the io supply, synchronous to i_clk.
 */
`timescale 1ns/1ps
module pwr_host_end #(
    parameter int HOLD_CYC = pwr_seq_pkg::RST_HOLD_CYC // reset hold count
) (
    input  wire logic i_clk,                     // system clock
    input  wire logic i_rst,                     // sync reset, high
    pwr_seq_if.host_mp link,                     // enable and reset out
    input  wire logic i_io_good,                 // io supply good
    input  wire logic i_power_req,               // level: want device on
    output logic      o_running                  // device released
);

    initial begin
        if (HOLD_CYC < 1) begin
            $error("reset hold must be at least one cycle");
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    pwr_seq_pkg::host_state_type state_reg;      // sequencer state
    pwr_seq_pkg::host_state_type state_next;
    logic [31:0]                 cnt_reg;        // hold counter
    logic [31:0]                 cnt_next;
    logic                        en_reg;         // chip enable drive
    logic                        en_next;
    logic                        rstn_reg;       // hard reset drive
    logic                        rstn_next;

    // next state, counter and pin levels
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            pwr_seq_pkg::HST_OFF: begin
                if (i_power_req) begin
                    state_next = pwr_seq_pkg::HST_WAIT_IO;
                end
            end
            pwr_seq_pkg::HST_WAIT_IO: begin
                if (!i_power_req) begin
                    state_next = pwr_seq_pkg::HST_OFF;
                end else if (i_io_good) begin
                    // enable only after supply is good
                    state_next = pwr_seq_pkg::HST_HOLD;
                    cnt_next   = 32'(HOLD_CYC - 1);
                end
            end
            pwr_seq_pkg::HST_HOLD: begin
                if (!i_power_req || !i_io_good) begin
                    state_next = pwr_seq_pkg::HST_DOWN;
                end else if (cnt_reg == 32'h0000_0000) begin
                    state_next = pwr_seq_pkg::HST_RUN;
                end else begin
                    cnt_next = cnt_reg - 32'h0000_0001;
                end
            end
            pwr_seq_pkg::HST_RUN: begin
                if (!i_power_req || !i_io_good) begin
                    state_next = pwr_seq_pkg::HST_DOWN;
                end
            end
            pwr_seq_pkg::HST_DOWN: begin
                state_next = pwr_seq_pkg::HST_OFF;
            end
            default: begin
                state_next = pwr_seq_pkg::HST_OFF;
            end
        endcase
        // pins are always driven to a level
        en_next   = (state_next == pwr_seq_pkg::HST_HOLD) ||
                    (state_next == pwr_seq_pkg::HST_RUN);
        // both fall in the same cycle on power-down
        rstn_next = (state_next == pwr_seq_pkg::HST_RUN);
    end

    // register sequencer state and pins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= pwr_seq_pkg::HST_OFF;
            cnt_reg   <= 32'h0000_0000;
            en_reg    <= 1'b0;
            rstn_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            en_reg    <= en_next;
            rstn_reg  <= rstn_next;
        end
    end

    assign link.chip_en        = en_reg;
    assign link.hard_reset_low = rstn_reg;
    assign o_running           = rstn_reg;

endmodule

// File: testbench/pwr_seq_sva.sv
/*
 * checker for the host/device pair: link timing and pad states.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module pwr_seq_sva #(
    parameter int PADS     = pwr_seq_pkg::NUM_PADS, // pad count
    parameter int HOLD_CYC = pwr_seq_pkg::RST_HOLD_CYC // reset hold
) (
    input wire logic            i_clk,          // clock
    input wire logic            i_rst,          // sync reset
    input wire logic            chip_en,        // core enable
    input wire logic            hard_reset_low, // reset, low active
    input wire logic            i_io_good,      // host supply good
    input wire logic            i_power_req,    // host request
    input wire logic            i_io_supply,    // device supply
    input wire logic [PADS-1:0] i_fw_oe,        // firmware drivers
    input wire logic [PADS-1:0] i_fw_pull,      // firmware pulls
    input wire logic [1:0]      o_state,        // device state
    input wire logic [PADS-1:0] o_pad_oe,       // pad drivers
    input wire logic [PADS-1:0] o_pad_ie,       // pad inputs
    input wire logic [PADS-1:0] o_pad_pull      // pad pulls
);
    // ---------------------------------------------------------------
    // enable-high counter and properties
    // ---------------------------------------------------------------
    logic [31:0] cnt_reg;                       // cycles enable stood
    logic [31:0] cnt_next;                      // next count
    // count while enable stands, clear when it drops
    always_comb cnt_next = chip_en ? cnt_reg + 32'h1 : 32'h0;
    always_ff @(posedge i_clk) cnt_reg <= i_rst ? 32'h0 : cnt_next;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_en; $rose(chip_en) |-> $past(i_io_good && i_power_req);
    endproperty
    a_en: assert property (p_en) else $error("early enable");
    // hold counter loads HOLD_CYC-1, so release lands HOLD_CYC edges on
    property p_hold; $rose(hard_reset_low) |-> cnt_reg == HOLD_CYC;
    endproperty
    a_hold: assert property (p_hold) else $error("hold count off");
    property p_down; (chip_en && !(i_io_good && i_power_req))
        |-> ##[1:2] (!chip_en && !hard_reset_low); endproperty
    a_down: assert property (p_down) else $error("late drop");
    property p_tog; $fell(chip_en) |-> !hard_reset_low; endproperty
    a_tog: assert property (p_tog) else $error("pins split");
    property p_off; (!chip_en || !i_io_supply) |=> o_state == 2'h0;
    endproperty
    a_off: assert property (p_off) else $error("not powered down");
    property p_dflt; (chip_en && hard_reset_low && i_io_supply &&
        o_state == 2'h1) |=> o_state == 2'h2; endproperty
    a_dflt: assert property (p_dflt) else $error("no default");
    property p_pdn; (o_state == 2'h0 && $past(o_state) == 2'h0)
        |-> {o_pad_oe, o_pad_ie, o_pad_pull} == '0; endproperty
    a_pdn: assert property (p_pdn) else $error("pads live off");
    property p_por; (o_state == 2'h1 && $past(o_state) == 2'h1)
        |-> o_pad_oe == '0 && o_pad_ie == '0 && &o_pad_pull; endproperty
    a_por: assert property (p_por) else $error("reset pads");
    property p_op; (o_state == 2'h3 && $past(o_state) == 2'h3 &&
        $stable(i_fw_oe) && $stable(i_fw_pull)) |-> o_pad_ie == ~o_pad_oe
        && o_pad_oe == $past(i_fw_oe) && o_pad_pull == $past(i_fw_pull);
    endproperty
    a_op: assert property (p_op) else $error("operate pads");
endmodule

// File: testbench/power_enable_reset_sequencer_test.sv
/*
 * bench: host and device ends joined by the link interface.
 * assumes package, interface, both ends and checker compile first.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module power_enable_reset_sequencer_test;
    // ---------------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------------
    localparam int PADS = pwr_seq_pkg::NUM_PADS; // pad count
    localparam int HOLD = 8;                     // short reset hold
    logic              clk = 1'b0, rst = 1'b1;   // clock, reset
    logic              io_good = 1'b0;           // host supply good
    logic              io_supply = 1'b0;         // device supply
    logic              power_req = 1'b0;         // want device on
    logic              cfg_done = 1'b0;          // firmware done
    logic [PADS-1:0]   fw_oe = '0, fw_pull = '0; // firmware settings
    logic              running;                  // host released
    logic [1:0]        state, last_st = 2'h0;    // device state
    logic [PADS-1:0]   oe, ie, pull;             // pad controls
    logic [3*PADS+1:0] notes[$], exp_n;          // expected results
    logic [3*PADS+1:0] seen;                     // state and pads seen
    logic [31:0]       r;                        // random word
    int mismatches = 0, samples_checked = 0, cycles = 0, n, m; // counts
    pwr_seq_if link ();                          // the link
    pwr_host_end #(.HOLD_CYC(HOLD)) i_pwr_host_end (.i_clk(clk),
        .i_rst(rst), .link(link), .i_io_good(io_good),
        .i_power_req(power_req), .o_running(running));
    pwr_dev_end #(.PADS(PADS)) i_pwr_dev_end (.i_clk(clk), .i_rst(rst),
        .link(link), .i_io_supply(io_supply), .i_fw_cfg_done(cfg_done),
        .i_fw_oe(fw_oe), .i_fw_pull(fw_pull), .o_state(state),
        .o_pad_oe(oe), .o_pad_ie(ie), .o_pad_pull(pull));
    pwr_seq_sva #(.PADS(PADS), .HOLD_CYC(HOLD)) i_pwr_seq_sva (.i_clk(clk),
        .i_rst(rst), .chip_en(link.chip_en),
        .hard_reset_low(link.hard_reset_low), .i_io_good(io_good),
        .i_power_req(power_req), .i_io_supply(io_supply), .i_fw_oe(fw_oe),
        .i_fw_pull(fw_pull), .o_state(state), .o_pad_oe(oe), .o_pad_ie(ie),
        .o_pad_pull(pull));
    assign seen = {state, oe, ie, pull};         // packed like a note
    always #10 clk = ~clk;                       // 50 MHz
    task automatic wrap_up;
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic note(input logic [1:0] s, input logic [PADS-1:0] o, i, p);
        notes.push_back({s, o, i, p});
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            wrap_up();
        end
    end
    // on a state move take the oldest note, let pads settle, compare
    always @(negedge clk) begin
        if (!rst && state !== last_st) begin
            last_st = state;
            exp_n = notes.size() > 0 ? notes.pop_front() : 'x;
            @(negedge clk);
            `CHK("pads", exp_n, seen)
        end
    end
    // power cycles, ended by request drop, supply loss, reset, early drop
    initial begin
        r = $urandom(32'hF13E);
        repeat (2) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            m = i % 4;
            r = $urandom();
            fw_oe = r[PADS-1:0];
            fw_pull = r[PADS+15:16];
            note(2'h1, '0, '0, '1);
            if (m != 3) note(2'h2, '0, '1, '1);
            if (m != 3) note(2'h3, fw_oe, ~fw_oe, fw_pull);
            note(2'h0, '0, '0, '0);
            power_req = 1'b1;
            io_supply = 1'b1;
            repeat (3) @(negedge clk);
            `CHK("enable before io good", 1'b0, link.chip_en)
            io_good = 1'b1;
            n = 0;
            // count cycles of enable high with reset still held
            for (int k = 0; k < 64 && link.hard_reset_low !== 1'b1 &&
                 !(m == 3 && n > 2); k++) begin
                @(negedge clk);
                n += int'(link.chip_en === 1'b1 && !link.hard_reset_low);
            end
            if (m == 3) power_req = 1'b0;
            else begin
                `CHK("reset hold cycles", HOLD, n)
                repeat (3) @(negedge clk);
                `CHK("running", 1'b1, running)
                cfg_done = 1'b1;
                repeat (4) @(negedge clk);
                power_req = (m == 1);
                io_good = (m != 1);
                io_supply = (m != 1);
                rst = (m == 2);
            end
            repeat (2) @(negedge clk);
            rst = 1'b0;
            repeat (2) @(negedge clk);
            `CHK("link pins", 2'b00, {link.chip_en, link.hard_reset_low})
            {power_req, io_good, cfg_done} = 3'h0;
            repeat (4) @(negedge clk);
        end
        wrap_up();
    end
endmodule
